// ---- src/pmhif_page_config.sv ----
`timescale 1ns/1ps
// Register bank for host-link paging and interface configuration.
// Link decoder hands in an 8-bit in-page address plus strobes on linkClk;
// everything crosses into clk where the registers live.
module pmhif_page_config
   import pmhif_pkg::*;
#(
   parameter int STALL_LIMIT = pmhif_pkg::STALL_CYCLES
) (
   // System
   input  wire logic       clk,
   input  wire logic       rst,
   // Link side, linkClk domain
   input  wire logic       linkClk,
   input  wire logic       linkRst,
   input  wire logic       linkWrite,
   input  wire logic       linkRead,
   input  wire logic [7:0] linkAddr,
   input  wire logic [7:0] linkWdata,
   input  wire logic       linkDone,
   input  wire logic       linkAddrUpper,
   // Raw pin levels
   input  wire logic       serialClockPin,
   // Fuse memory side
   input  wire logic [7:0] fuseLink,
   input  wire logic [7:0] fuseLink2,
   input  wire logic [7:0] fuseCfgA,
   input  wire logic       fuseLock,
   input  wire logic       fuseValid,
   input  wire logic       emulationActive,
   // Read data back to link
   output logic [7:0]      rdData,
   output logic            rdValid,
   // Decoded map and mode outputs
   output logic [8:0]      mappedAddr,
   output logic            mappedValid,
   output logic            repeatedWrite,
   output logic            fuseReload,
   output logic            fuseMarginRead,
   output logic            appSettingsFuseLock,
   output logic [3:0]      twoWireAddrHigh,
   output logic            directionBitPolarity,
   output logic            serialClockPhase,
   output logic            serialClockPolarity,
   output logic            selectPolarity,
   output logic            fourWireActive,
   output logic            sharedPinOverride,
   output logic            hsContinuousEnable,
   output logic            fastPlusEnable,
   output logic            twoWireReset
);
   import pmhif_pkg::*;

   logic [7:0] pageControl;
   logic [7:0] fuseReadControl;
   logic [7:0] hostLinkConfig;
   logic [7:0] hostLinkConfigTwo;
   logic [7:0] configA;
   logic       addrHighFromHw;
   logic       emulPrev;
   logic       loadedOnce;

   // Link-domain capture: words held stable until the event arrives in clk
   logic [7:0] holdAddr;
   logic [7:0] holdData;
   logic       holdWrite;
   logic       holdUpper;
   logic       linkEvent;

   always_ff @(posedge linkClk)
   begin
      if (linkRst)
      begin
         holdAddr  <= 8'h00;
         holdData  <= 8'h00;
         holdWrite <= 1'b0;
         holdUpper <= 1'b0;
      end
      else if (linkWrite || linkRead)
      begin
         holdAddr  <= linkAddr;
         holdData  <= linkWdata;
         holdWrite <= linkWrite;
         holdUpper <= linkAddrUpper;
      end
   end

   always_ff @(posedge linkClk)
   begin
      if (linkRst)
         linkEvent <= 1'b0;
      else
         linkEvent <= linkWrite || linkRead;
   end

   logic accPulse;
   logic donePulse;

   pmhif_pulse_xing uAccXing (
      .srcClk   (linkClk),
      .srcRst   (linkRst),
      .srcPulse (linkEvent),
      .dstClk   (clk),
      .dstRst   (rst),
      .dstPulse (accPulse)
   );

   pmhif_pulse_xing uDoneXing (
      .srcClk   (linkClk),
      .srcRst   (linkRst),
      .srcPulse (linkDone),
      .dstClk   (clk),
      .dstRst   (rst),
      .dstPulse (donePulse)
   );

   logic sckLevel;

   pmhif_sync #(.RESET_VAL(1'b1)) uSckSync (
      .clk  (clk),
      .rst  (rst),
      .din  (serialClockPin),
      .dout (sckLevel)
   );

   // Page decode; link side must not change held words before crossing ends
   wire  [2:0] page     = pageControl[2:0];
   wire        twoWire  = hostLinkConfigTwo[IF_TYPE_BIT];
   wire  [8:0] twMapped = {page[1], holdAddr};
   wire        twOk     = ~page[2] && ~(page[1] && holdAddr[7]);
   wire  [8:0] fwMapped = {page[1], page[0] & ~page[1], holdAddr[6:0]};
   wire        fwOk     = (page <= 3'h2) && ~holdAddr[7];
   wire        twHsAddr = twoWire && holdUpper;
   wire  [8:0] accAddr  = twoWire ? (twHsAddr ? {1'b1, holdAddr} : twMapped)
                                  : fwMapped;
   wire        accOk    = twoWire ? (twHsAddr ? ~holdAddr[7] : twOk) : fwOk;
   wire        wrAcc    = accPulse && holdWrite && accOk;
   wire        rdAcc    = accPulse && !holdWrite && accOk;
   wire        wrPage   = wrAcc && (accAddr == OFF_PAGE);
   wire        wrFuse   = wrAcc && (accAddr == OFF_FUSE);
   wire        wrLink   = wrAcc && (accAddr == OFF_LINK);
   wire        wrLink2  = wrAcc && (accAddr == OFF_LINK2);
   wire        wrCfgA   = wrAcc && (accAddr == OFF_CFGA);
   wire        reloadGo = wrFuse && holdData[RELOAD_BIT];
   wire        emulLeft = emulPrev && !emulationActive;
   wire        autoRet  = donePulse && pageControl[PAGE_RETURN_BIT];
   wire        startLd  = fuseValid && !loadedOnce;

   wire  [7:0] rdMux =
      (accAddr == OFF_PAGE)  ? pageControl       :
      (accAddr == OFF_FUSE)  ? fuseReadControl   :
      (accAddr == OFF_LINK)  ? hostLinkConfig    :
      (accAddr == OFF_LINK2) ? hostLinkConfigTwo :
      (accAddr == OFF_CFGA)  ? configA           : 8'h00;

   // Write to page takes effect on the very next decode
   always_ff @(posedge clk)
   begin
      if (rst)
         pageControl <= RST_PAGE;
      else if (wrPage)
         pageControl <= holdData & PAGE_MASK;
      else if (autoRet)
         pageControl <= {pageControl[7:3], 3'h0};
   end

   // Set from host wins over the automatic clear
   always_ff @(posedge clk)
   begin
      if (rst)
         fuseReadControl <= RST_FUSE;
      else if (wrFuse)
         fuseReadControl <= holdData & FUSE_MASK;
      else if (emulLeft)
         fuseReadControl[LOAD_DONE_BIT] <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hostLinkConfig    <= RST_LINK;
         hostLinkConfigTwo <= RST_LINK2;
         configA           <= RST_CFGA;
         appSettingsFuseLock <= 1'b0;
         addrHighFromHw    <= 1'b1;
      end
      else if (reloadGo || startLd)
      begin
         hostLinkConfig      <= fuseLink;
         hostLinkConfigTwo   <= fuseLink2 & LINK2_MASK;
         configA             <= fuseCfgA;
         appSettingsFuseLock <= fuseLock;
         addrHighFromHw      <= (fuseLink[7:4] == UNPROG_CODE);
      end
      else
      begin
         if (wrLink)
            hostLinkConfig <= holdData;
         if (wrLink2)
            hostLinkConfigTwo <= holdData & LINK2_MASK;
         if (wrCfgA)
            configA <= holdData;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         emulPrev   <= 1'b0;
         loadedOnce <= 1'b0;
      end
      else
      begin
         emulPrev <= emulationActive;
         if (fuseValid)
            loadedOnce <= 1'b1;
      end
   end

   // Stall watchdog on synchronised serial clock
   logic [$clog2(STALL_LIMIT+2)-1:0] stallCount;
   wire stallOn  = twoWire && configA[STALL_BIT];
   wire stallHit = stallCount > ($clog2(STALL_LIMIT+2))'(STALL_LIMIT);

   always_ff @(posedge clk)
   begin
      if (rst || !stallOn || sckLevel || stallHit)
         stallCount <= '0;
      else
         stallCount <= stallCount + 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdData      <= 8'h00;
         rdValid     <= 1'b0;
         mappedAddr  <= 9'h000;
         mappedValid <= 1'b0;
      end
      else
      begin
         rdValid     <= rdAcc;
         mappedValid <= wrAcc || rdAcc;
         if (rdAcc)
            rdData <= rdMux;
         if (accPulse)
            mappedAddr <= accAddr;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         repeatedWrite        <= 1'b0;
         fuseReload           <= 1'b0;
         fuseMarginRead       <= 1'b0;
         twoWireAddrHigh      <= HW_ADDR_HIGH;
         directionBitPolarity <= 1'b0;
         serialClockPhase     <= 1'b0;
         serialClockPolarity  <= 1'b0;
         selectPolarity       <= 1'b0;
         fourWireActive       <= 1'b0;
         sharedPinOverride    <= 1'b0;
         hsContinuousEnable   <= 1'b0;
         fastPlusEnable       <= 1'b0;
         twoWireReset         <= 1'b0;
      end
      else
      begin
         repeatedWrite        <= pageControl[WRITE_MODE_BIT];
         fuseReload           <= reloadGo;
         fuseMarginRead       <= fuseReadControl[MARGIN_BIT];
         twoWireAddrHigh      <= addrHighFromHw ? HW_ADDR_HIGH
                                                : hostLinkConfig[7:4];
         directionBitPolarity <= hostLinkConfig[DIR_POL_BIT];
         serialClockPhase     <= hostLinkConfig[PHASE_BIT];
         serialClockPolarity  <= hostLinkConfig[SERIAL_CLOCK_POLARITY_BIT];
         selectPolarity       <= hostLinkConfig[SEL_POL_BIT];
         fourWireActive       <= !twoWire;
         sharedPinOverride    <= !twoWire;
         hsContinuousEnable   <= hostLinkConfigTwo[HS_BIT];
         fastPlusEnable       <= hostLinkConfigTwo[FMP_BIT];
         twoWireReset         <= stallHit;
      end
   end
endmodule

// ---- src/pmhif_pkg.sv ----
package pmhif_pkg;
   localparam logic [8:0] OFF_PAGE  = 9'h100;
   localparam logic [8:0] OFF_FUSE  = 9'h101;
   localparam logic [8:0] OFF_LINK  = 9'h105;
   localparam logic [8:0] OFF_LINK2 = 9'h106;
   localparam logic [8:0] OFF_CFGA  = 9'h143;
   localparam int PAGE_RETURN_BIT = 7;
   localparam int WRITE_MODE_BIT  = 6;
   localparam int LOAD_DONE_BIT   = 3;
   localparam int RELOAD_BIT      = 2;
   localparam int MARGIN_BIT      = 0;
   localparam int DIR_POL_BIT     = 3;
   localparam int PHASE_BIT       = 2;
   localparam int SERIAL_CLOCK_POLARITY_BIT        = 1;
   localparam int SEL_POL_BIT     = 0;
   localparam int IF_TYPE_BIT     = 7;
   localparam int HS_BIT          = 6;
   localparam int FMP_BIT         = 5;
   localparam int STALL_BIT       = 4;
   localparam logic [7:0] PAGE_MASK  = 8'hC7;
   localparam logic [7:0] FUSE_MASK  = 8'h09;
   localparam logic [7:0] LINK2_MASK = 8'hF0;
   localparam logic [7:0] RST_PAGE   = 8'h00;
   localparam logic [7:0] RST_FUSE   = 8'h00;
   localparam logic [7:0] RST_LINK   = 8'hD0;
   localparam logic [7:0] RST_LINK2  = 8'h80;
   localparam logic [7:0] RST_CFGA   = 8'h00;
   localparam logic [3:0] HW_ADDR_HIGH = 4'hD;
   localparam logic [3:0] UNPROG_CODE  = 4'h0;
   localparam int STALL_MS = 35;
   localparam int CLK_MHZ  = 100;
   localparam int STALL_CYCLES = STALL_MS * 1000 * CLK_MHZ;
endpackage

// ---- src/pmhif_sync.sv ----
`timescale 1ns/1ps
// Three-stage input synchroniser; output moves when stages two and three agree
module pmhif_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s1   <= RESET_VAL;
         s2   <= RESET_VAL;
         s3   <= RESET_VAL;
         dout <= RESET_VAL;
      end
      else
      begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            dout <= s3;
      end
   end
endmodule

// ---- src/pmhif_pulse_xing.sv ----
`timescale 1ns/1ps
// Toggle crossing for one-cycle events into the destination clock
module pmhif_pulse_xing (
   input  wire logic srcClk,
   input  wire logic srcRst,
   input  wire logic srcPulse,
   input  wire logic dstClk,
   input  wire logic dstRst,
   output logic      dstPulse
);
   logic srcToggle;
   logic d1;
   logic d2;
   logic d3;
   always_ff @(posedge srcClk)
   begin
      if (srcRst)
         srcToggle <= 1'b0;
      else if (srcPulse)
         srcToggle <= ~srcToggle;
   end
   always_ff @(posedge dstClk)
   begin
      if (dstRst)
      begin
         d1       <= 1'b0;
         d2       <= 1'b0;
         d3       <= 1'b0;
         dstPulse <= 1'b0;
      end
      else
      begin
         d1       <= srcToggle;
         d2       <= d1;
         d3       <= d2;
         dstPulse <= d2 ^ d3;
      end
   end
endmodule

// ---- verif/pmhif_host_model.sv ----
`timescale 1ns/1ps
module pmhif_host_model (
   // Link clock
   input  wire logic       linkClk,
   // Request lines
   output logic            linkWrite,
   output logic            linkRead,
   output logic            linkDone,
   output logic            linkAddrUpper,
   output logic [7:0]      linkAddr,
   output logic [7:0]      linkWdata
);
   initial
   begin
      {linkWrite, linkRead, linkDone, linkAddrUpper} = 4'h0;
      {linkAddr, linkWdata} = 16'hA5A5;
   end
   // Twelve cycles per access so the crossing always drains first
   task automatic access(input logic wr, up, input logic [7:0] a, d, input logic done);
      @(posedge linkClk);
      {linkWrite, linkRead, linkAddrUpper} <= {wr, !wr, up};
      {linkAddr, linkWdata} <= {a, d};
      @(posedge linkClk);
      {linkWrite, linkRead, linkAddrUpper} <= {2'b00, !up};
      {linkAddr, linkWdata} <= ~{a, d};
      repeat (6) @(posedge linkClk);
      linkDone <= done;
      @(posedge linkClk);
      linkDone <= 1'b0;
      repeat (3) @(posedge linkClk);
   endtask
endmodule

// ---- verif/pmhif_page_config_monitor.sv ----
`timescale 1ns/1ps
module pmhif_page_config_monitor (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Watched outputs
   input  wire logic       rdValid,
   input  wire logic       mappedValid,
   input  wire logic [8:0] mappedAddr,
   input  wire logic       fuseReload,
   input  wire logic [3:0] twoWireAddrHigh,
   input  wire logic       fourWireActive,
   input  wire logic       sharedPinOverride,
   input  wire logic       twoWireReset
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence quietAfter;
      !mappedValid [*8];
   endsequence
   valid_spacing_a: assert property (mappedValid |=> quietAfter)
      else $error("Mapped valid repeated too soon");
   read_pulse_a: assert property (rdValid |=> !rdValid)
      else $error("Read valid longer than one cycle");
   reload_pulse_a: assert property (fuseReload |=> !fuseReload)
      else $error("Reload pulse longer than one cycle");
   addr_default_a: assert property (twoWireAddrHigh != 4'h0)
      else $error("Address high shows unprogrammed code");
   shared_pins_a: assert property (sharedPinOverride == fourWireActive)
      else $error("Pin override differs from link type");
   stall_gate_a: assert property (twoWireReset |-> !fourWireActive)
      else $error("Stall reset while four-wire link active");
   four_map_a: assert property (mappedValid && fourWireActive |-> mappedAddr <= 9'h17F)
      else $error("Four-wire access mapped beyond bank");
   two_map_a: assert property (mappedValid && !fourWireActive && mappedAddr[8] |-> !mappedAddr[7])
      else $error("Two-wire upper bank mapped too high");
endmodule
bind pmhif_page_config pmhif_page_config_monitor u_mon (.clk(clk), .rst(rst), .rdValid(rdValid),
   .mappedValid(mappedValid), .mappedAddr(mappedAddr), .fuseReload(fuseReload),
   .twoWireAddrHigh(twoWireAddrHigh), .fourWireActive(fourWireActive),
   .sharedPinOverride(sharedPinOverride), .twoWireReset(twoWireReset));

// ---- verif/tb_pmhif_page_config.sv ----
`timescale 1ns/1ps
module tb_pmhif_page_config;
   import pmhif_pkg::*;
   logic       clk, rst, linkClk, linkRst, linkWrite, linkRead, linkDone, linkAddrUpper;
   logic       serialClockPin, fuseLock, fuseValid, emulationActive, rdValid, mappedValid;
   logic [7:0] linkAddr, linkWdata, fuseLink, fuseLink2, fuseCfgA, rdData, lastRd;
   logic [8:0] mappedAddr, lastMap, flags;
   logic [3:0] twoWireAddrHigh;
   logic       repeatedWrite, fuseReload, fuseMarginRead, appSettingsFuseLock, twoWireReset;
   logic       directionBitPolarity, serialClockPhase, serialClockPolarity, selectPolarity;
   logic       fourWireActive, sharedPinOverride, hsContinuousEnable, fastPlusEnable;
   int         failures, checked, cycles, mapCount, reloadCount;
   assign flags = {appSettingsFuseLock, hsContinuousEnable, fastPlusEnable, fourWireActive,
      sharedPinOverride, directionBitPolarity, serialClockPhase, serialClockPolarity,
      selectPolarity};
   // Short stall limit keeps the run brief
   pmhif_page_config #(.STALL_LIMIT(20)) u_dut (.clk(clk), .rst(rst), .linkClk(linkClk),
      .linkRst(linkRst), .linkWrite(linkWrite), .linkRead(linkRead), .linkAddr(linkAddr),
      .linkWdata(linkWdata), .linkDone(linkDone), .linkAddrUpper(linkAddrUpper),
      .serialClockPin(serialClockPin), .fuseLink(fuseLink), .fuseLink2(fuseLink2),
      .fuseCfgA(fuseCfgA), .fuseLock(fuseLock), .fuseValid(fuseValid),
      .emulationActive(emulationActive), .rdData(rdData), .rdValid(rdValid),
      .mappedAddr(mappedAddr), .mappedValid(mappedValid), .repeatedWrite(repeatedWrite),
      .fuseReload(fuseReload), .fuseMarginRead(fuseMarginRead),
      .appSettingsFuseLock(appSettingsFuseLock), .twoWireAddrHigh(twoWireAddrHigh),
      .directionBitPolarity(directionBitPolarity), .serialClockPhase(serialClockPhase),
      .serialClockPolarity(serialClockPolarity), .selectPolarity(selectPolarity),
      .fourWireActive(fourWireActive), .sharedPinOverride(sharedPinOverride),
      .hsContinuousEnable(hsContinuousEnable), .fastPlusEnable(fastPlusEnable),
      .twoWireReset(twoWireReset));
   pmhif_host_model u_host (.linkClk(linkClk), .linkWrite(linkWrite), .linkRead(linkRead),
      .linkDone(linkDone), .linkAddrUpper(linkAddrUpper), .linkAddr(linkAddr),
      .linkWdata(linkWdata));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      linkClk = 1'b0;
      #7;
      forever #32 linkClk = ~linkClk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (mappedValid === 1'b1)
      begin
         lastMap <= mappedAddr;
         mapCount <= mapCount + 1;
      end
      if (rdValid === 1'b1)
         lastRd <= rdData;
      if (fuseReload === 1'b1)
         reloadCount <= reloadCount + 1;
      if (cycles == 20000)
      begin
         failures = failures + 1;
         end_sim();
      end
   end
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic wr, up, input logic [7:0] a, d, input logic done);
      u_host.access(wr, up, a, d, done);
      repeat (2) @(posedge clk);
   endtask
   task automatic reset_values();
      logic [7:0] adr [4] = '{8'h00, 8'h01, 8'h05, 8'h06};
      logic [7:0] exp [4] = '{8'h00, 8'h00, 8'hD0, 8'h80};
      foreach (adr[i])
      begin
         xfer(1'b0, 1'b1, adr[i], 8'h00, 1'b0);
         check({1'b0, lastRd}, {1'b0, exp[i]});
      end
      check(flags, 9'h000);
   endtask
   task automatic fuse_load();
      @(posedge clk);
      fuseValid <= 1'b1;
      repeat (20) @(posedge clk);
      check({5'h00, twoWireAddrHigh}, {5'h00, HW_ADDR_HIGH});
      check(flags, 9'h1CA);
   endtask
   task automatic paging();
      int n;
      xfer(1'b1, 1'b1, 8'h00, 8'h02, 1'b0);
      n = mapCount;
      xfer(1'b0, 1'b0, 8'h85, 8'h00, 1'b0);
      check(mapCount[8:0], n[8:0]);
      xfer(1'b0, 1'b0, 8'h05, 8'h00, 1'b0);
      check(lastMap, 9'h105);
      xfer(1'b1, 1'b1, 8'h00, 8'hC1, 1'b0);
      check({8'h00, repeatedWrite}, 9'h001);
      xfer(1'b0, 1'b0, 8'h05, 8'h00, 1'b1);
      check(lastMap, 9'h005);
      xfer(1'b0, 1'b1, 8'h00, 8'h00, 1'b0);
      check({1'b0, lastRd}, 9'h0C0);
   endtask
   task automatic fuse_control();
      @(posedge clk);
      emulationActive <= 1'b1;
      fuseLink2 <= 8'h80;
      xfer(1'b1, 1'b1, 8'h01, 8'h0D, 1'b0);
      check(flags, 9'h10A);
      check({8'h00, fuseMarginRead}, 9'h001);
      check(reloadCount[8:0], 9'h001);
      xfer(1'b0, 1'b1, 8'h01, 8'h00, 1'b0);
      check({1'b0, lastRd}, 9'h009);
      emulationActive <= 1'b0;
      repeat (10) @(posedge clk);
      xfer(1'b0, 1'b1, 8'h01, 8'h00, 1'b0);
      check({1'b0, lastRd}, 9'h001);
   endtask
   task automatic stall_reset();
      int n = 0;
      @(posedge clk);
      serialClockPin <= 1'b0;
      while (twoWireReset !== 1'b1 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      check({8'h00, twoWireReset}, 9'h001);
      check({8'h00, n > 20}, 9'h001);
      @(posedge clk);
      serialClockPin <= 1'b1;
   endtask
   task automatic four_wire();
      int n;
      xfer(1'b1, 1'b1, 8'h00, 8'h02, 1'b0);
      xfer(1'b1, 1'b0, 8'h06, 8'h00, 1'b0);
      xfer(1'b1, 1'b0, 8'h05, 8'hDF, 1'b0);
      check(lastMap, 9'h105);
      check(flags, 9'h13F);
      check({5'h00, twoWireAddrHigh}, 9'h00D);
      n = mapCount;
      xfer(1'b0, 1'b0, 8'h85, 8'h00, 1'b0);
      check(mapCount[8:0], n[8:0]);
      xfer(1'b1, 1'b0, 8'h00, 8'h01, 1'b0);
      xfer(1'b0, 1'b0, 8'h05, 8'h00, 1'b0);
      check(lastMap, 9'h085);
   endtask
   task automatic end_sim();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      {rst, linkRst, serialClockPin, fuseLock, fuseValid, emulationActive} = 6'h3C;
      {fuseLink, fuseLink2, fuseCfgA} = 24'h0AE010;
      {failures, checked, cycles, mapCount, reloadCount} = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      linkRst <= 1'b0;
      repeat (4) @(posedge clk);
      reset_values();
      fuse_load();
      paging();
      fuse_control();
      stall_reset();
      four_wire();
      end_sim();
   end
endmodule
